// ==== shared/tmr_pkg.sv ====
`default_nettype none

package tmr_pkg;

	// Register bus geometry.
	localparam int ADDR_W = 20;
	localparam int DATA_W = 8;

	// Byte addresses of the channel registers.
	localparam logic [19:0] OFF_CTRL  = 20'hfff68;
	localparam logic [19:0] OFF_IOC   = 20'hfff69;
	localparam logic [19:0] OFF_CNT_H = 20'hfff6a;
	localparam logic [19:0] OFF_CNT_L = 20'hfff6b;
	localparam logic [19:0] OFF_GNA_H = 20'hfff6c;
	localparam logic [19:0] OFF_GNA_L = 20'hfff6d;
	localparam logic [19:0] OFF_GNB_H = 20'hfff6e;
	localparam logic [19:0] OFF_GNB_L = 20'hfff6f;
	localparam logic [19:0] OFF_STAT  = 20'hfff66;
	localparam logic [19:0] OFF_MASK  = 20'hfff67;

	// Field positions inside the control and I/O control bytes.
	localparam int CTRL_PSC_LSB  = 0;
	localparam int CTRL_EDGE_LSB = 3;
	localparam int CTRL_CLR_LSB  = 5;
	localparam int IOC_A_LSB     = 0;
	localparam int IOC_B_LSB     = 4;

	// Values after reset and reserved bits that read as one.
	localparam logic [7:0]  CTRL_RSVD = 8'h80;
	localparam logic [7:0]  IOC_RSVD  = 8'h88;
	localparam logic [6:0]  CTRL_RST  = 7'h00;
	localparam logic [2:0]  IO_RST    = 3'h0;
	localparam logic [15:0] CNT_RST   = 16'h0000;
	localparam logic [15:0] GR_RST    = 16'hffff;
	localparam logic [2:0]  DIV_RST   = 3'h0;

	// Status and mask bit positions.
	localparam int ST_A   = 0;
	localparam int ST_B   = 1;
	localparam int ST_OVF = 2;
	localparam int ST_W   = 3;

	// Counter clear sources.
	localparam logic [1:0] CLR_NONE = 2'h0;
	localparam logic [1:0] CLR_A    = 2'h1;
	localparam logic [1:0] CLR_B    = 2'h2;
	localparam logic [1:0] CLR_SYNC = 2'h3;

	// One register bus request.
	typedef struct packed {
		logic [19:0] addr;
		logic [7:0]  wdata;
		logic        wr;
		logic        rd;
	} tmr_bus_s;

endpackage

`default_nettype wire

// ==== hdl/tmr_channel0.sv ====
// The strobed register port was decided locally.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// RULE1: Prescale top bit 0 counts internal clock divided by 1, 2, 4, 8.
// RULE2: Prescale top bit 1 counts external input A, B, C or D.
// RULE3: Edge field 00 rising, 01 falling, 1x both edges counted.
// RULE4: Clear field 00 never clears the counter automatically.
// RULE5: Clear field 01 clears on register A match or capture.
// RULE6: Clear field 10 clears on register B match or capture.
// RULE7: Clear field 11 clears together with synchronized channels.
// RULE8: A mode 000/001/010 compares; pin unchanged, driven 0, driven 1.
// RULE9: A mode 011 toggles the A pin on each compare match.
// RULE10: A mode 1xx captures counter on rising, falling or both edges.
// RULE11: B mode 000/001/010 compares; pin unchanged, driven 0, driven 1.
// RULE12: B mode 011 toggles the B pin on each compare match.
// RULE13: B mode 1xx captures counter on rising, falling or both edges.
// RULE14: Counter is 16 bits, byte accessible, resets to zero.
// RULE15: General register A is 16 bits, byte accessible, resets to ones.
// RULE16: I/O control bits 7 and 3 read one; mode bits reset zero.
// RULE17: Match raised when counter becomes equal; inputs edge detected on clock.
// RULE18: Software writes beat counting or capture in the same cycle.
module tmr_channel0 (
	input  wire logic              clock,
	input  wire logic              nrst,
	input  wire tmr_pkg::tmr_bus_s bus,
	output logic [7:0]             rdata_q,
	input  wire logic              ext_count_in_a,
	input  wire logic              ext_count_in_b,
	input  wire logic              ext_count_in_c,
	input  wire logic              ext_count_in_d,
	input  wire logic              pin_a_in,
	output logic                   pin_a_out_q,
	output logic                   pin_a_oe_q,
	input  wire logic              pin_b_in,
	output logic                   pin_b_out_q,
	output logic                   pin_b_oe_q,
	input  wire logic              sync_clear_in,
	output logic                   sync_clear_out_q,
	output logic                   irq_q
);

	logic [6:0]  ctrl_q;
	logic [2:0]  a_mode_q, b_mode_q;
	logic [15:0] cnt_q, general_reg_a_q, general_reg_b_q;
	logic [2:0]  div_q;
	logic [3:0]  ext_prev_q;
	logic        cap_a_prev_q, cap_b_prev_q;
	logic        eq_a_q, eq_b_q;
	logic [2:0]  stat_q, stat_d, mask_q;

	logic [2:0]  psc;
	logic [1:0]  edge_sel;
	logic [1:0]  clr_src;
	logic [3:0]  ext_vec;
	logic        int_tick, ext_tick, tick;
	logic        eq_a, eq_b, match_a, match_b;
	logic        cap_a, cap_b, event_a, event_b;
	logic        clear, ovf;
	logic        wr_ctrl, wr_ioc, wr_cnt, wr_gna, wr_gnb;
	logic        wr_cnt_h, wr_cnt_l, wr_gna_h, wr_gna_l, wr_gnb_h, wr_gnb_l;

	// Picks rising, falling or both edges from a two-bit selector.
	function automatic logic edge_hit(input logic [1:0] sel, input logic now, input logic prev);
		logic rise;
		logic fall;
		rise = now & ~prev;
		fall = ~now & prev;
		edge_hit = sel[1] ? (rise | fall) : (sel[0] ? fall : rise);
	endfunction

	// Control fields and register write decode.
	assign psc      = ctrl_q[tmr_pkg::CTRL_PSC_LSB +: 3];
	assign edge_sel = ctrl_q[tmr_pkg::CTRL_EDGE_LSB +: 2];
	assign clr_src  = ctrl_q[tmr_pkg::CTRL_CLR_LSB +: 2];
	assign ext_vec  = {ext_count_in_d, ext_count_in_c, ext_count_in_b, ext_count_in_a};
	assign wr_ctrl  = bus.wr && (bus.addr == tmr_pkg::OFF_CTRL);
	assign wr_ioc   = bus.wr && (bus.addr == tmr_pkg::OFF_IOC);
	assign wr_cnt_h = bus.wr && (bus.addr == tmr_pkg::OFF_CNT_H);
	assign wr_cnt_l = bus.wr && (bus.addr == tmr_pkg::OFF_CNT_L);
	assign wr_gna_h = bus.wr && (bus.addr == tmr_pkg::OFF_GNA_H);
	assign wr_gna_l = bus.wr && (bus.addr == tmr_pkg::OFF_GNA_L);
	assign wr_gnb_h = bus.wr && (bus.addr == tmr_pkg::OFF_GNB_H);
	assign wr_gnb_l = bus.wr && (bus.addr == tmr_pkg::OFF_GNB_L);
	assign wr_cnt   = wr_cnt_h | wr_cnt_l;
	assign wr_gna   = wr_gna_h | wr_gna_l;
	assign wr_gnb   = wr_gnb_h | wr_gnb_l;

	// Internal tick from the free-running divider.
	always_comb begin
		unique case (psc[1:0])
			2'h0: int_tick = 1'b1; // RULE1
			2'h1: int_tick = div_q[0]; // RULE1
			2'h2: int_tick = &div_q[1:0]; // RULE1
			default: int_tick = &div_q[2:0]; // RULE1
		endcase
	end

	// External tick from the selected input and edge choice.
	assign ext_tick = edge_hit(edge_sel, ext_vec[psc[1:0]], ext_prev_q[psc[1:0]]); // RULE2 RULE3
	assign tick     = psc[2] ? ext_tick : int_tick; // RULE2

	// Compare matches fire when the counter becomes equal to the register.
	assign eq_a    = (cnt_q == general_reg_a_q);
	assign eq_b    = (cnt_q == general_reg_b_q);
	assign match_a = ~a_mode_q[2] & eq_a & ~eq_a_q; // RULE17
	assign match_b = ~b_mode_q[2] & eq_b & ~eq_b_q; // RULE17
	assign cap_a   = a_mode_q[2] & edge_hit(a_mode_q[1:0], pin_a_in, cap_a_prev_q); // RULE10
	assign cap_b   = b_mode_q[2] & edge_hit(b_mode_q[1:0], pin_b_in, cap_b_prev_q); // RULE13
	assign event_a = match_a | cap_a;
	assign event_b = match_b | cap_b;

	// Counter clear source selection.
	always_comb begin
		unique case (clr_src)
			tmr_pkg::CLR_NONE: clear = 1'b0; // RULE4
			tmr_pkg::CLR_A:    clear = event_a; // RULE5
			tmr_pkg::CLR_B:    clear = event_b; // RULE6
			default:           clear = sync_clear_in; // RULE7
		endcase
	end

	assign ovf = tick & ~clear & ~wr_cnt & (cnt_q == 16'hffff);

	// Prescaler divider and input history, sampled on the system clock.
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			div_q        <= tmr_pkg::DIV_RST;
			ext_prev_q   <= 4'h0;
			cap_a_prev_q <= 1'b0;
			cap_b_prev_q <= 1'b0;
			eq_a_q       <= 1'b0;
			eq_b_q       <= 1'b0;
		end else begin
			div_q        <= div_q + 3'h1;
			ext_prev_q   <= ext_vec; // RULE17
			cap_a_prev_q <= pin_a_in; // RULE17
			cap_b_prev_q <= pin_b_in; // RULE17
			eq_a_q       <= eq_a;
			eq_b_q       <= eq_b;
		end
	end

	// Control and I/O control registers.
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			ctrl_q   <= tmr_pkg::CTRL_RST;
			a_mode_q <= tmr_pkg::IO_RST; // RULE16
			b_mode_q <= tmr_pkg::IO_RST; // RULE16
		end else begin
			if (wr_ctrl) begin
				ctrl_q <= bus.wdata[6:0];
			end
			if (wr_ioc) begin
				a_mode_q <= bus.wdata[tmr_pkg::IOC_A_LSB +: 3];
				b_mode_q <= bus.wdata[tmr_pkg::IOC_B_LSB +: 3];
			end
		end
	end

	// Channel counter: software write, then clear, then count.
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			cnt_q <= tmr_pkg::CNT_RST; // RULE14
		end else if (wr_cnt_h) begin
			cnt_q[15:8] <= bus.wdata; // RULE18
		end else if (wr_cnt_l) begin
			cnt_q[7:0] <= bus.wdata; // RULE18
		end else if (clear) begin
			cnt_q <= tmr_pkg::CNT_RST;
		end else if (tick) begin
			cnt_q <= cnt_q + 16'h0001; // RULE14
		end
	end

	// General registers: software write wins over capture.
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			general_reg_a_q <= tmr_pkg::GR_RST; // RULE15
			general_reg_b_q <= tmr_pkg::GR_RST;
		end else begin
			if (wr_gna_h) begin
				general_reg_a_q[15:8] <= bus.wdata; // RULE18
			end else if (wr_gna_l) begin
				general_reg_a_q[7:0] <= bus.wdata; // RULE18
			end else if (cap_a) begin
				general_reg_a_q <= cnt_q; // RULE10
			end
			if (wr_gnb_h) begin
				general_reg_b_q[15:8] <= bus.wdata; // RULE18
			end else if (wr_gnb_l) begin
				general_reg_b_q[7:0] <= bus.wdata; // RULE18
			end else if (cap_b) begin
				general_reg_b_q <= cnt_q; // RULE13
			end
		end
	end

	// Pin A action on compare match; driven only in modes 001 to 011.
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			pin_a_out_q <= 1'b0;
			pin_a_oe_q  <= 1'b0;
		end else begin
			pin_a_oe_q <= ~a_mode_q[2] & (a_mode_q[1:0] != 2'h0); // RULE8
			if (match_a) begin
				unique case (a_mode_q[1:0])
					2'h0: pin_a_out_q <= pin_a_out_q; // RULE8
					2'h1: pin_a_out_q <= 1'b0; // RULE8
					2'h2: pin_a_out_q <= 1'b1; // RULE8
					default: pin_a_out_q <= ~pin_a_out_q; // RULE9
				endcase
			end
		end
	end

	// Pin B action on compare match; driven only in modes 001 to 011.
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			pin_b_out_q <= 1'b0;
			pin_b_oe_q  <= 1'b0;
		end else begin
			pin_b_oe_q <= ~b_mode_q[2] & (b_mode_q[1:0] != 2'h0); // RULE11
			if (match_b) begin
				unique case (b_mode_q[1:0])
					2'h0: pin_b_out_q <= pin_b_out_q; // RULE11
					2'h1: pin_b_out_q <= 1'b0; // RULE11
					2'h2: pin_b_out_q <= 1'b1; // RULE11
					default: pin_b_out_q <= ~pin_b_out_q; // RULE12
				endcase
			end
		end
	end

	// Sticky status: a new event wins over a write-one clear.
	always_comb begin
		stat_d = stat_q;
		if (bus.wr && (bus.addr == tmr_pkg::OFF_STAT)) begin
			stat_d = stat_q & ~bus.wdata[2:0];
		end
		stat_d[tmr_pkg::ST_A]   = stat_d[tmr_pkg::ST_A] | event_a;
		stat_d[tmr_pkg::ST_B]   = stat_d[tmr_pkg::ST_B] | event_b;
		stat_d[tmr_pkg::ST_OVF] = stat_d[tmr_pkg::ST_OVF] | ovf;
	end

	// Status, mask, interrupt and clear broadcast.
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			stat_q           <= 3'h0;
			mask_q           <= 3'h0;
			irq_q            <= 1'b0;
			sync_clear_out_q <= 1'b0;
		end else begin
			stat_q           <= stat_d;
			irq_q            <= |(stat_d & mask_q);
			sync_clear_out_q <= clear & (clr_src != tmr_pkg::CLR_SYNC);
			if (bus.wr && (bus.addr == tmr_pkg::OFF_MASK)) begin
				mask_q <= bus.wdata[2:0];
			end
		end
	end

	// Read data, valid in the cycle after the read strobe.
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			rdata_q <= 8'h00;
		end else if (bus.rd) begin
			unique case (bus.addr)
				tmr_pkg::OFF_CTRL:  rdata_q <= tmr_pkg::CTRL_RSVD | {1'b0, ctrl_q};
				tmr_pkg::OFF_IOC:   rdata_q <= tmr_pkg::IOC_RSVD | {1'b0, b_mode_q, 1'b0, a_mode_q}; // RULE16
				tmr_pkg::OFF_CNT_H: rdata_q <= cnt_q[15:8];
				tmr_pkg::OFF_CNT_L: rdata_q <= cnt_q[7:0];
				tmr_pkg::OFF_GNA_H: rdata_q <= general_reg_a_q[15:8];
				tmr_pkg::OFF_GNA_L: rdata_q <= general_reg_a_q[7:0];
				tmr_pkg::OFF_GNB_H: rdata_q <= general_reg_b_q[15:8];
				tmr_pkg::OFF_GNB_L: rdata_q <= general_reg_b_q[7:0];
				tmr_pkg::OFF_STAT:  rdata_q <= {5'h00, stat_q};
				tmr_pkg::OFF_MASK:  rdata_q <= {5'h00, mask_q};
				default:            rdata_q <= 8'h00;
			endcase
		end else begin
			rdata_q <= 8'h00;
		end
	end

	// Divide-by-two prescale never ticks twice in a row.
	a_div_two: assert property (@(posedge clock) disable iff (!nrst) // RULE1
		(psc == 3'b001 && int_tick) ##1 (psc == 3'b001) |-> !int_tick)
		else $error("divide by two ticked on consecutive cycles");

	// A selected external rising edge advances the counter by one.
	a_ext_count: assert property (@(posedge clock) disable iff (!nrst) // RULE2
		(psc[2] && edge_sel == 2'b00 && ext_vec[psc[1:0]] && !ext_prev_q[psc[1:0]]
		&& !clear && !wr_cnt) |=> cnt_q == $past(cnt_q) + 16'h0001)
		else $error("external rising edge did not advance the counter");

	// Falling-edge mode ignores rising edges.
	a_fall_only: assert property (@(posedge clock) disable iff (!nrst) // RULE3
		(psc[2] && edge_sel == 2'b01 && ext_vec[psc[1:0]] && !ext_prev_q[psc[1:0]]) |-> !tick)
		else $error("rising edge counted in falling edge mode");

	// Without a clear source and without a tick the counter holds.
	a_no_clear: assert property (@(posedge clock) disable iff (!nrst) // RULE4
		(clr_src == tmr_pkg::CLR_NONE && !tick && !wr_cnt) |=> $stable(cnt_q))
		else $error("counter changed with no clear source and no tick");

	// Register A event clears the counter when selected.
	a_clear_a: assert property (@(posedge clock) disable iff (!nrst) // RULE5
		(clr_src == tmr_pkg::CLR_A && event_a && !wr_cnt) |=> cnt_q == 16'h0000)
		else $error("register A event did not clear the counter");

	// Register B event clears the counter when selected.
	a_clear_b: assert property (@(posedge clock) disable iff (!nrst) // RULE6
		(clr_src == tmr_pkg::CLR_B && event_b && !wr_cnt) |=> cnt_q == 16'h0000)
		else $error("register B event did not clear the counter");

	// Synchronous clear follows the other channels.
	a_sync_clear: assert property (@(posedge clock) disable iff (!nrst) // RULE7
		(clr_src == tmr_pkg::CLR_SYNC && sync_clear_in && !wr_cnt) |=> cnt_q == 16'h0000)
		else $error("synchronous clear was missed");

	// Pin A driven low on match in mode 001.
	a_pin_a_low: assert property (@(posedge clock) disable iff (!nrst) // RULE8
		(a_mode_q == 3'b001 && match_a) |=> !pin_a_out_q ##1 pin_a_oe_q)
		else $error("pin A not driven low on match");

	// Pin A toggles on match in mode 011.
	a_pin_a_tgl: assert property (@(posedge clock) disable iff (!nrst) // RULE9
		(a_mode_q == 3'b011 && match_a) |=> pin_a_out_q != $past(pin_a_out_q))
		else $error("pin A did not toggle on match");

	// Capture A latches the counter value of the edge cycle.
	a_cap_a_val: assert property (@(posedge clock) disable iff (!nrst) // RULE10
		(cap_a && !wr_gna) |=> general_reg_a_q == $past(cnt_q))
		else $error("register A did not capture the counter");

	// Pin B driven high on match in mode 010.
	a_pin_b_high: assert property (@(posedge clock) disable iff (!nrst) // RULE11
		(b_mode_q == 3'b010 && match_b) |=> pin_b_out_q)
		else $error("pin B not driven high on match");

	// Pin B toggles on match in mode 011.
	a_pin_b_tgl: assert property (@(posedge clock) disable iff (!nrst) // RULE12
		(b_mode_q == 3'b011 && match_b) |=> pin_b_out_q != $past(pin_b_out_q))
		else $error("pin B did not toggle on match");

	// Capture B latches the counter value of the edge cycle.
	a_cap_b_val: assert property (@(posedge clock) disable iff (!nrst) // RULE13
		(cap_b && !wr_gnb) |=> general_reg_b_q == $past(cnt_q))
		else $error("register B did not capture the counter");

	// Reserved I/O control bits read back as one.
	a_ioc_rsvd: assert property (@(posedge clock) disable iff (!nrst) // RULE16
		(bus.rd && bus.addr == tmr_pkg::OFF_IOC) |=> rdata_q[7] && rdata_q[3])
		else $error("reserved I/O control bits did not read as one");

	// A low byte write beats a tick in the same cycle.
	a_write_wins: assert property (@(posedge clock) disable iff (!nrst) // RULE18
		(wr_cnt_l && tick) |=> cnt_q[7:0] == $past(bus.wdata))
		else $error("count overrode a software write");

endmodule

`default_nettype wire

// ==== bench/tb_tmr_channel0.sv ====
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin errors++; $display("ERROR %s expected %0h seen %0h", nm, ex, got); end end

module tb_tmr_channel0;
	logic              clock;
	logic              nrst;
	tmr_pkg::tmr_bus_s bus;
	logic [7:0]        rdata_q;
	logic [3:0]        ext_in;
	logic              pin_a_in;
	logic              pin_a_out_q;
	logic              pin_a_oe_q;
	logic              pin_b_in;
	logic              pin_b_out_q;
	logic              pin_b_oe_q;
	logic              sync_clear_in;
	logic              sync_clear_out_q;
	logic              irq_q;
	int                errors;
	int                checked;
	int                pulses;

	tmr_channel0 u_tmr_channel0 (
		.clock           (clock),
		.nrst            (nrst),
		.bus             (bus),
		.rdata_q         (rdata_q),
		.ext_count_in_a  (ext_in[0]),
		.ext_count_in_b  (ext_in[1]),
		.ext_count_in_c  (ext_in[2]),
		.ext_count_in_d  (ext_in[3]),
		.pin_a_in        (pin_a_in),
		.pin_a_out_q     (pin_a_out_q),
		.pin_a_oe_q      (pin_a_oe_q),
		.pin_b_in        (pin_b_in),
		.pin_b_out_q     (pin_b_out_q),
		.pin_b_oe_q      (pin_b_oe_q),
		.sync_clear_in   (sync_clear_in),
		.sync_clear_out_q(sync_clear_out_q),
		.irq_q           (irq_q)
	);

	// The system clock, 25 ns period.
	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end

	task automatic final_report;
		if (errors == 0 && checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge clock);
	endtask

	// One write cycle, then one idle cycle so the strobe is never set twice in a step.
	task automatic reg_wr(input logic [19:0] a, input logic [7:0] d);
		bus.addr <= a;
		bus.wdata <= d;
		bus.wr <= 1'b1;
		@(posedge clock);
		bus.wr <= 1'b0;
		@(posedge clock);
	endtask

	// One read cycle; the data is taken in the following cycle, away from the edge.
	task automatic reg_rd(input logic [19:0] a, output logic [7:0] d);
		bus.addr <= a;
		bus.rd <= 1'b1;
		@(posedge clock);
		bus.rd <= 1'b0;
		@(negedge clock);
		d = rdata_q;
		@(posedge clock);
	endtask

	task automatic wr16(input logic [19:0] a, input logic [15:0] v);
		reg_wr(a, v[15:8]);
		reg_wr(a + 20'h1, v[7:0]);
	endtask

	task automatic rd16(input logic [19:0] a, output logic [15:0] v);
		reg_rd(a, v[15:8]);
		reg_rd(a + 20'h1, v[7:0]);
	endtask

	// Stops the counter on an idle external input, zeroes it, then starts it with cfg.
	task automatic load(input logic [7:0] cfg);
		reg_wr(tmr_pkg::OFF_CTRL, 8'h04);
		reg_wr(tmr_pkg::OFF_CNT_H, 8'h00);
		reg_wr(tmr_pkg::OFF_CNT_L, 8'h00);
		reg_wr(tmr_pkg::OFF_CTRL, cfg);
	endtask

	// One pulse on external input s; the other inputs carry noise that must not count.
	task automatic ext_pulse(input int s);
		logic [3:0] lv;
		for (int i = 0; i < 6; i++) begin
			lv = 4'($urandom);
			lv[s] = (i < 3);
			ext_in <= lv;
			@(posedge clock);
		end
	endtask

	// Cuts a hung run short.
	initial begin
		wait_cyc(20000);
		errors++;
		final_report();
	end

	// Counts clear broadcast pulses, sampled away from the edge that launches them.
	always @(negedge clock) begin
		if (sync_clear_out_q === 1'b1) begin
			pulses++;
		end
	end

	// Main sequence: counter expectations are fixed constants; only the pin levels are modelled.
	initial begin
		logic [7:0]  r1;
		logic [7:0]  r2;
		logic [15:0] g;
		logic [15:0] v;
		int          pa;
		int          m;
		int          p0;
		int          modes[5] = '{2, 1, 3, 3, 0};
		int          clr_exp[5] = '{41, 8, 16, 19, 41};
		errors = 0;
		checked = 0;
		nrst = 1'b0;
		bus = '0;
		ext_in = 4'h0;
		pin_a_in = 1'b0;
		pin_b_in = 1'b0;
		sync_clear_in = 1'b0;
		void'($urandom(82407));
		wait_cyc(3);
		nrst <= 1'b1;
		@(posedge clock);
		reg_rd(tmr_pkg::OFF_CTRL, r1);
		`CHK("control reset", 8'h80, r1)
		reg_rd(tmr_pkg::OFF_IOC, r1);
		`CHK("io control reset", 8'h88, r1)
		reg_rd(tmr_pkg::OFF_CNT_H, r1);
		`CHK("counter high reset", 8'h00, r1)
		rd16(tmr_pkg::OFF_GNA_H, g);
		`CHK("general a reset", 16'hffff, g)
		reg_rd(20'hfff70, r1);
		`CHK("unmapped read", 8'h00, r1)
		reg_wr(tmr_pkg::OFF_IOC, 8'h00);
		reg_rd(tmr_pkg::OFF_IOC, r1);
		`CHK("io control reserved", 8'h88, r1)
		reg_wr(tmr_pkg::OFF_IOC, 8'h77);
		reg_rd(tmr_pkg::OFF_IOC, r1);
		`CHK("io control write", 8'hff, r1)
		reg_wr(tmr_pkg::OFF_IOC, 8'h00);
		repeat (4) begin
			v = 16'($urandom);
			wr16(tmr_pkg::OFF_GNA_H, v);
			rd16(tmr_pkg::OFF_GNA_H, g);
			`CHK("general a rw", v, g)
		end
		// A low byte write while counting every cycle lands, then one count follows.
		reg_wr(tmr_pkg::OFF_CNT_L, 8'h5a);
		reg_rd(tmr_pkg::OFF_CNT_L, r1);
		`CHK("counter write wins", 8'h5b, r1)
		// Internal prescaler: ticks over 32 cycles.
		for (int d = 0; d < 4; d++) begin
			load(8'(d));
			reg_rd(tmr_pkg::OFF_CNT_L, r1);
			wait_cyc(30);
			reg_rd(tmr_pkg::OFF_CNT_L, r2);
			`CHK("prescale ticks", 8'(32 >> d), 8'(r2 - r1))
		end
		// External inputs with every edge code, five pulses each.
		for (int s = 0; s < 4; s++) begin
			for (int e = 0; e < 4; e++) begin
				reg_wr(tmr_pkg::OFF_CTRL, 8'(4 + s + e * 8));
				reg_rd(tmr_pkg::OFF_CNT_L, r1);
				repeat (5) ext_pulse(s);
				ext_in <= 4'h0;
				wait_cyc(3);
				reg_rd(tmr_pkg::OFF_CNT_L, r2);
				`CHK("external ticks", 8'(e > 1 ? 10 : 5), 8'(r2 - r1))
			end
		end
		// Clear sources: none, A match, B match, synchronous, none with a sync pulse.
		wr16(tmr_pkg::OFF_GNA_H, 16'h0020);
		wr16(tmr_pkg::OFF_GNB_H, 16'h0018);
		for (int c = 0; c < 5; c++) begin
			load(8'(c == 4 ? 0 : c * 32));
			p0 = pulses;
			for (int i = 0; i < 40; i++) begin
				sync_clear_in <= (c > 2 && i == 20);
				@(posedge clock);
			end
			reg_rd(tmr_pkg::OFF_CNT_L, r1);
			`CHK("cleared count", 8'(clr_exp[c]), r1)
			`CHK("clear broadcast", int'(c == 1 || c == 2), pulses - p0)
		end
		// Compare output actions on both pins.
		wr16(tmr_pkg::OFF_GNA_H, 16'h0040);
		wr16(tmr_pkg::OFF_GNB_H, 16'h0030);
		pa = 0;
		for (int j = 0; j < 5; j++) begin
			m = modes[j];
			reg_wr(tmr_pkg::OFF_IOC, 8'(m * 16 + m));
			load(8'h00);
			wait_cyc(80);
			pa = (m == 1) ? 0 : (m == 2) ? 1 : (m == 3) ? 1 - pa : pa;
			@(negedge clock);
			`CHK("pin a level", 1'(pa), pin_a_out_q)
			`CHK("pin b level", 1'(pa), pin_b_out_q)
			`CHK("pin a enable", 1'(m != 0), pin_a_oe_q)
			`CHK("pin b enable", 1'(m != 0), pin_b_oe_q)
			@(posedge clock);
		end
		// Sticky event flags behind the mask.
		reg_rd(tmr_pkg::OFF_STAT, r1);
		`CHK("status events", 8'h03, r1)
		@(negedge clock);
		`CHK("irq masked", 1'b0, irq_q)
		@(posedge clock);
		reg_wr(tmr_pkg::OFF_MASK, 8'h01);
		@(negedge clock);
		`CHK("irq unmasked", 1'b1, irq_q)
		@(posedge clock);
		reg_wr(tmr_pkg::OFF_STAT, 8'h01);
		reg_rd(tmr_pkg::OFF_STAT, r1);
		`CHK("status cleared", 8'h02, r1)
		@(negedge clock);
		`CHK("irq after clear", 1'b0, irq_q)
		@(posedge clock);
		reg_wr(tmr_pkg::OFF_MASK, 8'h02);
		@(negedge clock);
		`CHK("irq b event", 1'b1, irq_q)
		@(posedge clock);
		reg_wr(tmr_pkg::OFF_STAT, 8'h02);
		reg_wr(tmr_pkg::OFF_MASK, 8'h00);
		// Input capture on rising, falling and both edges.
		for (int k = 4; k < 8; k++) begin
			reg_wr(tmr_pkg::OFF_IOC, 8'(k * 16 + k));
			wr16(tmr_pkg::OFF_GNA_H, 16'h1234);
			wr16(tmr_pkg::OFF_GNB_H, 16'h1234);
			load(8'h00);
			wait_cyc(10);
			pin_a_in <= 1'b1;
			pin_b_in <= 1'b1;
			wait_cyc(10);
			rd16(tmr_pkg::OFF_GNA_H, g);
			`CHK("capture a rise", 16'(k == 5 ? 16'h1234 : 11), g)
			rd16(tmr_pkg::OFF_GNB_H, g);
			`CHK("capture b rise", 16'(k == 5 ? 16'h1234 : 11), g)
			pin_a_in <= 1'b0;
			pin_b_in <= 1'b0;
			wait_cyc(10);
			rd16(tmr_pkg::OFF_GNA_H, g);
			`CHK("capture a fall", 16'(k == 4 ? 11 : 29), g)
			rd16(tmr_pkg::OFF_GNB_H, g);
			`CHK("capture b fall", 16'(k == 4 ? 11 : 29), g)
		end
		final_report();
	end
endmodule

`default_nettype wire
